/* hw/t16if_top.sv */
// Interrupt enable and flag logic of a 16-bit timer with an APB register port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R1: Capture enable and global enable request capture.
// R2: Compare A enable and global enable request.
// R3: Compare B enable and global enable request.
// R4: Overflow enable and global enable request.
// R5: Capture pin edge sets capture flag.
// R6: Capture-as-TOP mode sets flag at TOP.
// R7: Capture vector execution clears capture flag.
// R8: Writing one clears capture flag.
// R9: Compare A match sets flag next cycle.
// R10: Force compare A never sets flag.
// R11: Compare A flag cleared by vector, write or flag read.
// R12: Compare B match sets flag next cycle.
// R13: Force compare B never sets flag.
// R14: Compare B flag cleared by vector, write or flag read.
// R15: Overflow flag set point follows waveform mode.
// R16: Overflow flag cleared by vector, write or flag read.
// R17: Capture copies counter into capture value.
// R18: Capture pin ignored when capture is TOP.
// R19: Set beats clear in the same cycle.
module t16if_top
    import t16if_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire t16if_apb_req_type apb_req,
    output t16if_apb_rsp_type apb_rsp,
    // Timer counter side.
    input wire t16if_timer_type timer,
    input wire logic capture_input_pin,
    // CPU interrupt side.
    input wire logic global_irq_enable,
    input wire logic [7:0] vector_done,
    output logic [7:0] irq_req,
    output logic irq,
    output logic [15:0] capture_value_reg
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    t16if_state_type s_r;
    t16if_state_type s_nxt;

    logic pin_edge;
    logic icr_top;
    logic [15:0] top_value;
    logic top_hit;
    logic ovf_set;
    logic eq_a;
    logic eq_b;
    logic set_a;
    logic set_b;
    logic cap_set;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic acc_first;
    logic xfer_done;
    logic wr_done;
    logic rd_done;
    logic addr_ok;
    t16if_top_type top_src;
    t16if_ovf_type ovf_src;

    // -------------------------------------------------------------------------
    // Event detection
    // -------------------------------------------------------------------------
    assign top_src = t16if_top_src(timer.waveform_mode_select);
    assign ovf_src = t16if_ovf_src(timer.waveform_mode_select);
    assign icr_top = (top_src == TOP_ICR);
    // R5: capture pin edge
    assign pin_edge = s_r.edge_rise ? (s_r.pin_s2 & ~s_r.pin_prev)
                                    : (~s_r.pin_s2 & s_r.pin_prev);

    always_comb begin
        case (top_src)
            TOP_8: top_value = TOP_8BIT;
            TOP_9: top_value = TOP_9BIT;
            TOP_10: top_value = TOP_10BIT;
            TOP_ICR: top_value = s_r.icr;
            TOP_OCRA: top_value = timer.compare_a_value;
            default: top_value = CNT_MAX;
        endcase
    end

    assign top_hit = timer.timer_tick && (timer.counter_value == top_value);

    // R15: overflow point per mode
    always_comb begin
        case (ovf_src)
            OVF_AT_MAX: ovf_set = timer.timer_tick && (timer.counter_value == CNT_MAX);
            OVF_AT_TOP: ovf_set = top_hit;
            OVF_AT_BOTTOM: ovf_set = timer.timer_tick && timer.count_down
                                     && (timer.counter_value == CNT_BOTTOM);
            default: ovf_set = 1'b0;
        endcase
    end

    // R9: compare A match edge
    assign eq_a = (timer.counter_value == timer.compare_a_value);
    assign set_a = eq_a & ~s_r.eq_a_prev;
    // R12: compare B match edge
    assign eq_b = (timer.counter_value == timer.compare_b_value);
    assign set_b = eq_b & ~s_r.eq_b_prev;
    // R6: capture source select
    assign cap_set = icr_top ? top_hit : pin_edge;

    // R10: force strobes excluded
    // R13: force strobes excluded
    always_comb begin
        set_vec = 8'h00;
        set_vec[BIT_CAP] = cap_set;
        set_vec[BIT_CMPA] = set_a;
        set_vec[BIT_CMPB] = set_b;
        set_vec[BIT_OVF] = ovf_set;
    end

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    assign acc_first = apb_req.psel && apb_req.penable && !s_r.pready;
    assign xfer_done = apb_req.psel && apb_req.penable && s_r.pready;
    assign wr_done = xfer_done && apb_req.pwrite && !s_r.pslverr;
    assign rd_done = xfer_done && !apb_req.pwrite && !s_r.pslverr;
    assign addr_ok = (apb_req.paddr == OFS_MASK) || (apb_req.paddr == OFS_FLAGS)
                     || (apb_req.paddr == OFS_CAPTURE) || (apb_req.paddr == OFS_CTRL);

    // R7: vector execution clear
    // R8: write one clear
    // R11: compare A clear
    // R14: compare B clear
    // R16: overflow clear
    always_comb begin
        clr_vec = vector_done & FLAG_BITS;
        if (wr_done && (apb_req.paddr == OFS_FLAGS)) begin
            clr_vec = clr_vec | (apb_req.pwdata[7:0] & FLAG_BITS);
        end
        if (rd_done && (apb_req.paddr == OFS_FLAGS)) begin
            clr_vec = clr_vec | (s_r.prdata[7:0] & FLAG_BITS);
        end
    end

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.pin_s1 = capture_input_pin;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_prev = s_r.pin_s2;
        s_nxt.eq_a_prev = eq_a;
        s_nxt.eq_b_prev = eq_b;
        // R19: set wins over clear
        s_nxt.flags = (s_r.flags & ~clr_vec) | set_vec;
        if (wr_done && (apb_req.paddr == OFS_MASK)) begin
            s_nxt.mask = apb_req.pwdata[7:0] & FLAG_BITS;
        end
        if (wr_done && (apb_req.paddr == OFS_CTRL)) begin
            s_nxt.edge_rise = apb_req.pwdata[CTRL_EDGE_BIT];
        end
        // R17: capture copies counter
        // R18: pin ignored in TOP mode
        if (cap_set && !icr_top) begin
            s_nxt.icr = timer.counter_value;
        end else if (wr_done && icr_top && (apb_req.paddr == OFS_CAPTURE)) begin
            s_nxt.icr = apb_req.pwdata[15:0];
        end
        s_nxt.pready = acc_first;
        s_nxt.pslverr = acc_first && !addr_ok;
        s_nxt.prdata = RDATA_ZERO;
        if (acc_first) begin
            case (apb_req.paddr)
                OFS_MASK: s_nxt.prdata = {24'h00_0000, s_r.mask};
                OFS_FLAGS: s_nxt.prdata = {24'h00_0000, s_r.flags};
                OFS_CAPTURE: s_nxt.prdata = {16'h0000, s_r.icr};
                OFS_CTRL: s_nxt.prdata = {31'h0000_0000, s_r.edge_rise};
                default: s_nxt.prdata = RDATA_ZERO;
            endcase
        end
        // R1: capture request gating
        // R2: compare A request gating
        // R3: compare B request gating
        // R4: overflow request gating
        s_nxt.irq_req = s_nxt.flags & s_nxt.mask & {8{global_irq_enable}};
        s_nxt.irq = |(s_nxt.flags & s_nxt.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{mask: MASK_RESET, flags: FLAGS_RESET, icr: ICR_RESET,
                     edge_rise: EDGE_RESET, prdata: RDATA_ZERO, irq_req: 8'h00,
                     default: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign apb_rsp = '{prdata: s_r.prdata, pready: s_r.pready, pslverr: s_r.pslverr};
    assign irq_req = s_r.irq_req;
    assign irq = s_r.irq;
    assign capture_value_reg = s_r.icr;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    cap_request_a: assert property (irq_req[BIT_CAP] == (s_r.flags[BIT_CAP]  // R1
        && s_r.mask[BIT_CAP] && $past(global_irq_enable)))
        else $error("capture request does not follow flag and enables");

    cmpa_request_a: assert property ((s_r.flags[BIT_CMPA] && s_r.mask[BIT_CMPA]  // R2
        && global_irq_enable && !clr_vec[BIT_CMPA] && !wr_done) |=> irq_req[BIT_CMPA])
        else $error("compare A request missing");

    cmpb_request_a: assert property (!s_r.mask[BIT_CMPB] |-> !irq_req[BIT_CMPB])  // R3
        else $error("compare B request while disabled");

    ovf_request_a: assert property ((!global_irq_enable) |=> (irq_req == 8'h00))  // R4
        else $error("request while globally disabled");

    cap_pin_set_a: assert property ((pin_edge && !icr_top) |=> s_r.flags[BIT_CAP])  // R5
        else $error("capture edge did not set flag");

    cap_top_set_a: assert property ((icr_top && top_hit) |=> s_r.flags[BIT_CAP])  // R6
        else $error("capture TOP did not set flag");

    cap_vec_clr_a: assert property ((vector_done[BIT_CAP] && !cap_set)  // R7
        |=> !s_r.flags[BIT_CAP])
        else $error("capture vector did not clear flag");

    cap_w1c_a: assert property ((wr_done && apb_req.paddr == OFS_FLAGS  // R8
        && apb_req.pwdata[BIT_CAP] && !cap_set) |=> !s_r.flags[BIT_CAP])
        else $error("write one did not clear capture flag");

    cmpa_set_a: assert property ((eq_a && !$past(eq_a)) |=> s_r.flags[BIT_CMPA])  // R9
        else $error("compare A match did not set flag");

    cmpa_force_a: assert property ((timer.force_compare_a && !set_a  // R10
        && !s_r.flags[BIT_CMPA]) |=> !s_r.flags[BIT_CMPA])
        else $error("force compare A set flag");

    cmpb_set_a: assert property (set_b |=> s_r.flags[BIT_CMPB])  // R12
        else $error("compare B match did not set flag");

    cmpb_force_a: assert property ((timer.force_compare_b && !set_b  // R13
        && !s_r.flags[BIT_CMPB]) |=> !s_r.flags[BIT_CMPB])
        else $error("force compare B set flag");

    flag_clear_a: assert property ((vector_done[BIT_CMPB] && !set_b)  // R14
        |=> !s_r.flags[BIT_CMPB])
        else $error("compare B vector did not clear flag");

    ovf_max_a: assert property ((ovf_src == OVF_AT_MAX && timer.timer_tick  // R15
        && timer.counter_value == CNT_MAX) |=> s_r.flags[BIT_OVF])
        else $error("overflow at MAX did not set flag");

    ovf_clear_a: assert property ((vector_done[BIT_OVF] && !ovf_set)  // R16
        |=> !s_r.flags[BIT_OVF])
        else $error("overflow vector did not clear flag");

    cap_copy_a: assert property ((pin_edge && !icr_top)  // R17
        |=> (capture_value_reg == $past(timer.counter_value)))
        else $error("capture value not copied");

    pin_blocked_a: assert property ((icr_top && pin_edge && !top_hit  // R18
        && !s_r.flags[BIT_CAP]) |=> !s_r.flags[BIT_CAP])
        else $error("pin capture while capture is TOP");

    set_wins_a: assert property ((set_a && clr_vec[BIT_CMPA])  // R19
        |=> s_r.flags[BIT_CMPA])
        else $error("clear beat a set event");

    cmpa_vec_clr_a: assert property ((vector_done[BIT_CMPA] && !set_a)  // R11
        |=> !s_r.flags[BIT_CMPA])
        else $error("compare A vector did not clear flag");

    ovf_w1c_a: assert property ((wr_done && apb_req.paddr == OFS_FLAGS  // R16
        && apb_req.pwdata[BIT_OVF] && !ovf_set) |=> !s_r.flags[BIT_OVF])
        else $error("write one did not clear overflow flag");

    icr_hold_a: assert property ((icr_top && !wr_done)  // R18
        |=> $stable(capture_value_reg))
        else $error("capture value moved while capture is TOP");

endmodule // t16if_top

`default_nettype wire

/* pkg/t16if_pkg.sv */
// Constants, types and mode decoding for the timer interrupt flag block.
package t16if_pkg;

    // -------------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_MASK = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h00C;

    // -------------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------------
    localparam int BIT_CAP = 5;
    localparam int BIT_CMPA = 4;
    localparam int BIT_CMPB = 3;
    localparam int BIT_OVF = 2;
    localparam int CTRL_EDGE_BIT = 0;
    localparam logic [7:0] FLAG_BITS = 8'h3C;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] ICR_RESET = 16'h0000;
    localparam logic EDGE_RESET = 1'b0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // -------------------------------------------------------------------------
    // Counter values
    // -------------------------------------------------------------------------
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {TOP_MAX, TOP_8, TOP_9, TOP_10, TOP_ICR, TOP_OCRA} t16if_top_type;
    typedef enum logic [1:0] {OVF_AT_MAX, OVF_AT_TOP, OVF_AT_BOTTOM, OVF_NONE} t16if_ovf_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } t16if_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } t16if_apb_rsp_type;

    typedef struct packed {
        logic [15:0] counter_value;
        logic [15:0] compare_a_value;
        logic [15:0] compare_b_value;
        logic [3:0] waveform_mode_select;
        logic timer_tick;
        logic count_down;
        logic force_compare_a;
        logic force_compare_b;
    } t16if_timer_type;

    // -------------------------------------------------------------------------
    // Mode decoding
    // -------------------------------------------------------------------------
    function automatic t16if_top_type t16if_top_src(input logic [3:0] mode);
        case (mode)
            4'h1, 4'h5: return TOP_8;
            4'h2, 4'h6: return TOP_9;
            4'h3, 4'h7: return TOP_10;
            4'h4, 4'h9, 4'hB, 4'hF: return TOP_OCRA;
            4'h8, 4'hA, 4'hC, 4'hE: return TOP_ICR;
            default: return TOP_MAX;
        endcase
    endfunction

    function automatic t16if_ovf_type t16if_ovf_src(input logic [3:0] mode);
        case (mode)
            4'h0, 4'h4, 4'hC: return OVF_AT_MAX;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: return OVF_AT_TOP;
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: return OVF_AT_BOTTOM;
            default: return OVF_NONE;
        endcase
    endfunction

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] flags;
        logic [15:0] icr;
        logic edge_rise;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic eq_a_prev;
        logic eq_b_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [7:0] irq_req;
    } t16if_state_type;

endpackage

/* verif/t16if_cpu_model.sv */
// Behavioural CPU vectoring model that executes requested timer vectors.
`timescale 1ns/10ps
`default_nettype none
module t16if_cpu_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bench controls.
    input wire logic ack_en,
    input wire logic slow,
    // Interrupt side.
    input wire logic [7:0] irq_req,
    output logic [7:0] vector_done
);
    logic [3:0] dly_r;
    logic [7:0] pick_r;

    // Highest requested source wins.
    function automatic logic [7:0] first_src(input logic [7:0] r);
        for (int i = 5; i >= 2; i--) begin
            if (r[i]) begin
                return 8'h01 << i;
            end
        end
        return 8'h00;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_done <= 8'h00;
            dly_r <= 4'h0;
            pick_r <= 8'h00;
        end else begin
            vector_done <= 8'h00;
            if (dly_r != 4'h0) begin
                dly_r <= dly_r - 4'h1;
                if (dly_r == 4'h1) begin
                    vector_done <= pick_r;
                end
            end else if (ack_en && (|irq_req[5:2]) && vector_done == 8'h00) begin
                dly_r <= slow ? 4'h4 : 4'h1;
                pick_r <= first_src(irq_req);
            end
        end
    end
endmodule // t16if_cpu_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench of the timer interrupt flag block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import t16if_pkg::*;
    logic pclk, presetn, pin, glob, ack_en, slow;
    t16if_apb_req_type req;
    t16if_apb_rsp_type rsp;
    t16if_timer_type tmr;
    logic [7:0] vdone, irq_req;
    logic irq;
    logic [15:0] capv;
    logic [31:0] rd;
    logic err;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    t16if_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .timer(tmr), .capture_input_pin(pin), .global_irq_enable(glob),
        .vector_done(vdone), .irq_req(irq_req), .irq(irq), .capture_value_reg(capv));
    t16if_cpu_model cpu (.pclk(pclk), .presetn(presetn), .ack_en(ack_en), .slow(slow),
        .irq_req(irq_req), .vector_done(vdone));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            $display("ERROR t=%0t timeout", $time);
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp, "read data");
    endtask
    task automatic ev_chk(input logic [7:0] exp);
        @(posedge pclk);
        chk({24'h00_0000, irq_req}, {24'h00_0000, exp}, "irq_req");
    endtask
    task automatic tick_at(input logic [15:0] v);
        @(posedge pclk);
        tmr.counter_value <= v;
        tmr.timer_tick <= 1'b1;
        @(posedge pclk);
        tmr.timer_tick <= 1'b0;
    endtask
    initial begin
        req = '0;
        tmr = '0;
        tmr.compare_a_value = 16'h0100;
        tmr.compare_b_value = 16'h0200;
        pin = 1'b1;
        glob = 1'b1;
        ack_en = 1'b0;
        slow = 1'b1;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFS_MASK, 32'h0000_0000);
        rd_chk(OFS_FLAGS, 32'h0000_0000);
        xfer(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001, "unmapped error");
        xfer(1'b1, OFS_MASK, 32'h0000_00FF);
        rd_chk(OFS_MASK, 32'h0000_003C);
        @(posedge pclk);
        tmr.force_compare_a <= 1'b1;
        tmr.force_compare_b <= 1'b1;
        @(posedge pclk);
        tmr.force_compare_a <= 1'b0;
        tmr.force_compare_b <= 1'b0;
        repeat (2) @(posedge pclk);
        ev_chk(8'h00);
        tick_at(16'h0100);
        ev_chk(8'h10);
        glob <= 1'b0;
        repeat (2) @(posedge pclk);
        ev_chk(8'h00);
        chk({31'h0, irq}, 32'h0000_0001, "irq level");
        glob <= 1'b1;
        tick_at(16'h0200);
        ev_chk(8'h18);
        tick_at(16'hFFFF);
        ev_chk(8'h1C);
        @(posedge pclk);
        tmr.counter_value <= 16'h1234;
        pin <= 1'b0;
        repeat (6) @(posedge pclk);
        ev_chk(8'h3C);
        chk({16'h0, capv}, 32'h0000_1234, "capture value");
        xfer(1'b1, OFS_FLAGS, 32'h0000_0000);
        ev_chk(8'h3C);
        for (int i = 5; i >= 2; i--) begin
            xfer(1'b1, OFS_FLAGS, 32'h0000_0001 << i);
            ev_chk(8'h3C & ~(8'hFF << i));
        end
        ack_en <= 1'b1;
        pin <= 1'b1;
        tick_at(16'h0100);
        tick_at(16'hFFFF);
        pin <= 1'b0;
        repeat (40) @(posedge pclk);
        ev_chk(8'h00);
        rd_chk(OFS_FLAGS, 32'h0000_0000);
        ack_en <= 1'b0;
        tick_at(16'h0200);
        rd_chk(OFS_FLAGS, 32'h0000_0008);
        rd_chk(OFS_FLAGS, 32'h0000_0000);
        @(posedge pclk);
        tmr.waveform_mode_select <= 4'h8;
        xfer(1'b1, OFS_CAPTURE, 32'h0000_0500);
        pin <= 1'b1;
        repeat (6) @(posedge pclk);
        pin <= 1'b0;
        repeat (6) @(posedge pclk);
        ev_chk(8'h00);
        tick_at(16'h0500);
        ev_chk(8'h20);
        chk({16'h0, capv}, 32'h0000_0500, "capture top");
        rd_chk(OFS_FLAGS, 32'h0000_0020);
        tmr.waveform_mode_select <= 4'h0;
        xfer(1'b1, OFS_CTRL, 32'h0000_0001);
        rd_chk(OFS_CTRL, 32'h0000_0001);
        tmr.counter_value <= 16'h0777;
        pin <= 1'b1;
        repeat (6) @(posedge pclk);
        ev_chk(8'h20);
        xfer(1'b1, OFS_CAPTURE, 32'h0000_0123);
        rd_chk(OFS_CAPTURE, 32'h0000_0777);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
